// ### verilog/mrc_pkg.sv
// constants, register map and types of the microcontroller reset controller
package mrc_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int STARTUP_DELAY_NS = 50_000_000;
    localparam int STARTUP_DELAY_CYC = (STARTUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // no figure given for the qualifying brownout time: plain default
    localparam int BROWNOUT_MIN_NS = 1_000;
    localparam int BROWNOUT_MIN_CYC = (BROWNOUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_SHORT_CYC = 2;
    localparam int WAKE_LONG_CYC = 128;

    // register byte addresses
    localparam logic [7:0] ADR_CONFIG = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_CAUSE = 8'h08;
    localparam logic [7:0] ADR_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] ADR_IRQ_MASK = 8'h10;

    // config fields
    localparam int CFG_LVR_EN = 0;
    localparam int CFG_THR_LSB = 1;
    localparam int CFG_WAKE_SHORT = 3;
    localparam int CFG_OSC_RC = 4;
    localparam int CFG_WIDTH = 5;
    localparam logic [4:0] CFG_RESET = 5'h01;

    // status fields
    localparam int STS_TO = 0;
    localparam int STS_PDF = 1;
    localparam int STS_LVR_ACT = 2;
    localparam int STS_PIN = 3;
    localparam int STS_STATE_LSB = 4;

    // event / cause bits, shared by cause, irq status and irq mask
    localparam int EV_PIN = 0;
    localparam int EV_LVR = 1;
    localparam int EV_WDT_RUN = 2;
    localparam int EV_WDT_SLEEP = 3;
    localparam int EV_WIDTH = 4;
    localparam logic [3:0] EV_RESET = 4'h0;

    // init control vector handed to the core
    localparam int INIT_IRQ_OFF = 0;
    localparam int INIT_TIMER_OFF = 1;
    localparam int INIT_PRESC_CLR = 2;
    localparam int INIT_IO_INPUT = 3;
    localparam int INIT_SP_TOP = 4;
    localparam int INIT_WIDTH = 5;

    typedef enum logic [3:0] {
        MRC_HOLD = 4'h1,
        MRC_DELAY = 4'h2,
        MRC_WAKE = 4'h4,
        MRC_RUN = 4'h8
    } mrc_state_t;
endpackage

// ### verilog/mrc_reset_ctrl.sv
// reset source merger, start-up timing and reset flags with a wishbone register port
`timescale 1ns/100ps
`default_nettype none
module mrc_reset_ctrl
    import mrc_pkg::*;
#(
    parameter int STARTUP_CYCLES = STARTUP_DELAY_CYC,
    parameter int BROWNOUT_CYCLES = BROWNOUT_MIN_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    // reset sources
    input wire logic external_clear_pin_n,
    input wire logic low_supply,
    input wire logic watchdog_timeout,
    input wire logic sleep_mode,
    input wire logic core_clr_wdt,
    input wire logic core_halt,
    // to the supply comparator and the core
    output logic [1:0] brownout_threshold,
    output logic core_reset,
    output logic core_run,
    output logic pc_sp_clear,
    output logic [4:0] core_init,
    output logic watchdog_clear,
    output logic watchdog_timeout_flag,
    output logic power_down_flag
);
    localparam int DLY_W = $clog2(STARTUP_CYCLES + 1);
    localparam int BO_W = $clog2(BROWNOUT_CYCLES + 2);
    localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(STARTUP_CYCLES - 1);
    localparam logic [BO_W-1:0] BO_LIMIT = BO_W'(BROWNOUT_CYCLES + 1);
    localparam logic [6:0] WAKE_SHORT_LAST = 7'(WAKE_SHORT_CYC - 1);
    localparam logic [6:0] WAKE_LONG_LAST = 7'(WAKE_LONG_CYC - 1);

    mrc_state_t state_reg;
    mrc_state_t state_next;
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic [BO_W-1:0] bo_cnt_reg;
    logic [DLY_W-1:0] dly_cnt_reg;
    logic [6:0] wake_cnt_reg;
    logic [CFG_WIDTH-1:0] cfg_reg;
    logic [EV_WIDTH-1:0] cause_reg;
    logic [EV_WIDTH-1:0] irq_sts_reg;
    logic [EV_WIDTH-1:0] irq_mask_reg;
    logic [EV_WIDTH-1:0] ev_now;
    logic [31:0] rd_data;
    logic wb_req;
    logic wb_wr;
    logic pin_low;
    logic lvr_active;
    logic wdt_run_ev;
    logic wdt_sleep_ev;
    logic full_src;
    logic hold_src;
    logic dly_done;
    logic wake_done;
    logic [6:0] wake_last;

    // the first stage feeds only the second stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_meta_reg <= 1'b1;
            pin_sync_reg <= 1'b1;
        end else begin
            pin_meta_reg <= external_clear_pin_n;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign pin_low = !pin_sync_reg;

    // brownout qualifier: supply must stay low for more than the minimum time
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bo_cnt_reg <= '0;
        end else if (!low_supply || !cfg_reg[CFG_LVR_EN]) begin
            bo_cnt_reg <= '0;
        end else if (bo_cnt_reg != BO_LIMIT) begin
            bo_cnt_reg <= bo_cnt_reg + BO_W'(1);
        end
    end

    // held only while the supply stays low, so the hold ends with the dip and the start-up delay follows
    assign lvr_active = cfg_reg[CFG_LVR_EN] && low_supply && (bo_cnt_reg == BO_LIMIT);

    // a timeout while asleep in the run state is a wake, not a full reset
    assign wdt_run_ev = watchdog_timeout && !(sleep_mode && state_reg == MRC_RUN);
    assign wdt_sleep_ev = watchdog_timeout && sleep_mode && state_reg == MRC_RUN;

    assign hold_src = pin_low || lvr_active;
    assign full_src = hold_src || wdt_run_ev;

    assign dly_done = dly_cnt_reg == DLY_LAST;
    assign wake_last = (cfg_reg[CFG_OSC_RC] && cfg_reg[CFG_WAKE_SHORT]) ?
        WAKE_SHORT_LAST : WAKE_LONG_LAST;
    assign wake_done = wake_cnt_reg == wake_last;

    always_comb begin
        state_next = state_reg;
        if (full_src) begin
            state_next = MRC_HOLD;
        end else begin
            unique case (state_reg)
                MRC_HOLD: begin
                    state_next = MRC_DELAY;
                end
                MRC_DELAY: begin
                    if (dly_done) begin
                        state_next = MRC_RUN;
                    end
                end
                MRC_WAKE: begin
                    if (wake_done) begin
                        state_next = MRC_RUN;
                    end
                end
                MRC_RUN: begin
                    if (wdt_sleep_ev) begin
                        state_next = MRC_WAKE;
                    end
                end
                default: begin
                    state_next = MRC_HOLD;
                end
            endcase
        end
    end

    // power-on starts straight in the start-up delay
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= MRC_DELAY;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dly_cnt_reg <= '0;
        end else if (state_reg != MRC_DELAY || state_next != MRC_DELAY) begin
            dly_cnt_reg <= '0;
        end else begin
            dly_cnt_reg <= dly_cnt_reg + DLY_W'(1);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wake_cnt_reg <= '0;
        end else if (state_reg != MRC_WAKE || state_next != MRC_WAKE) begin
            wake_cnt_reg <= '0;
        end else begin
            wake_cnt_reg <= wake_cnt_reg + 7'h01;
        end
    end

    // core controls, taken from the next state (pc_sp_clear from the sleep timeout) so they leave flip-flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core_reset <= 1'b1;
            core_run <= 1'b0;
            pc_sp_clear <= 1'b0;
            core_init <= '1;
            watchdog_clear <= 1'b1;
        end else begin
            core_reset <= state_next == MRC_HOLD || state_next == MRC_DELAY;
            core_run <= state_next == MRC_RUN;
            // only pc and sp are touched by a sleep timeout
            pc_sp_clear <= wdt_sleep_ev && !full_src;
            core_init[INIT_IRQ_OFF] <= state_next == MRC_HOLD || state_next == MRC_DELAY;
            core_init[INIT_TIMER_OFF] <= state_next == MRC_HOLD || state_next == MRC_DELAY;
            core_init[INIT_PRESC_CLR] <= state_next == MRC_HOLD || state_next == MRC_DELAY;
            core_init[INIT_IO_INPUT] <= state_next == MRC_HOLD || state_next == MRC_DELAY;
            core_init[INIT_SP_TOP] <= state_next == MRC_HOLD || state_next == MRC_DELAY;
            // held clear during reset; released the moment the core runs
            watchdog_clear <= state_next == MRC_HOLD || state_next == MRC_DELAY;
        end
    end

    // flags: power-on clears both, hardware set wins over core clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            watchdog_timeout_flag <= 1'b0;
        end else if (watchdog_timeout) begin
            watchdog_timeout_flag <= 1'b1;
        end else if (core_clr_wdt || core_halt) begin
            watchdog_timeout_flag <= 1'b0;
        end
    end

    // pin and low voltage resets leave this flag alone
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            power_down_flag <= 1'b0;
        end else if (wdt_sleep_ev || core_halt) begin
            power_down_flag <= 1'b1;
        end else if (core_clr_wdt) begin
            power_down_flag <= 1'b0;
        end
    end

    // events for cause and interrupt logic, one per source entry
    always_comb begin
        ev_now = '0;
        ev_now[EV_PIN] = pin_low && state_reg != MRC_HOLD;
        ev_now[EV_LVR] = lvr_active && state_reg != MRC_HOLD;
        ev_now[EV_WDT_RUN] = wdt_run_ev;
        ev_now[EV_WDT_SLEEP] = wdt_sleep_ev;
    end

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // writes commit on the ack edge, where the master completes the cycle
    assign wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_reg <= CFG_RESET;
            irq_mask_reg <= EV_RESET;
        end else if (wb_wr) begin
            if (wb_adr_i == ADR_CONFIG) begin
                cfg_reg <= wb_dat_i[CFG_WIDTH-1:0];
            end
            if (wb_adr_i == ADR_IRQ_MASK) begin
                irq_mask_reg <= wb_dat_i[EV_WIDTH-1:0];
            end
        end
    end

    // last reset cause: newest events replace the record
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cause_reg <= EV_RESET;
        end else if (|ev_now) begin
            cause_reg <= ev_now;
        end
    end

    // sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_sts_reg <= EV_RESET;
        end else if (wb_wr && wb_adr_i == ADR_IRQ_STATUS) begin
            irq_sts_reg <= (irq_sts_reg & ~wb_dat_i[EV_WIDTH-1:0]) | ev_now;
        end else begin
            irq_sts_reg <= irq_sts_reg | ev_now;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_sts_reg & irq_mask_reg);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            brownout_threshold <= CFG_RESET[CFG_THR_LSB+1:CFG_THR_LSB];
        end else begin
            brownout_threshold <= cfg_reg[CFG_THR_LSB+1:CFG_THR_LSB];
        end
    end

    always_comb begin
        rd_data = '0;
        unique case (wb_adr_i)
            ADR_CONFIG: begin
                rd_data[CFG_WIDTH-1:0] = cfg_reg;
            end
            ADR_STATUS: begin
                rd_data[STS_TO] = watchdog_timeout_flag;
                rd_data[STS_PDF] = power_down_flag;
                rd_data[STS_LVR_ACT] = lvr_active;
                rd_data[STS_PIN] = pin_sync_reg;
                rd_data[STS_STATE_LSB+3:STS_STATE_LSB] = state_reg;
            end
            ADR_CAUSE: begin
                rd_data[EV_WIDTH-1:0] = cause_reg;
            end
            ADR_IRQ_STATUS: begin
                rd_data[EV_WIDTH-1:0] = irq_sts_reg;
            end
            ADR_IRQ_MASK: begin
                rd_data[EV_WIDTH-1:0] = irq_mask_reg;
            end
            default: begin
                rd_data = '0;
            end
        endcase
    end

    // one wait state: ack a cycle after the request, dropped the next cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                wb_dat_o <= rd_data;
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/mrc_clear_switch.sv
// model of the external clear switch with its rc hold-off
`timescale 1ns/100ps
`default_nettype none
module mrc_clear_switch #(
    parameter int RC_CYC = 3
) (
    input wire logic clk,
    input wire logic press,
    output logic pin_n
);
    int hold = 0;
    // rc keeps the pin low a few cycles after the switch opens
    always @(posedge clk) begin
        if (press) begin
            hold <= RC_CYC;
        end else if (hold > 0) begin
            hold <= hold - 1;
        end
    end
    assign pin_n = !(press || hold > 0);
endmodule
`default_nettype wire

// ### dv/mrc_reset_ctrl_checker.sv
// concurrent checks on the reset controller ports
`timescale 1ns/100ps
`default_nettype none
module mrc_reset_ctrl_checker #(
    parameter int STARTUP_CYCLES = 20
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic external_clear_pin_n,
    input wire logic watchdog_timeout,
    input wire logic sleep_mode,
    input wire logic core_reset,
    input wire logic core_run,
    input wire logic pc_sp_clear,
    input wire logic [4:0] core_init,
    input wire logic watchdog_clear,
    input wire logic watchdog_timeout_flag,
    input wire logic power_down_flag
);
    int hold_cnt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // length of the current reset hold, a repetition would be too long
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_cnt <= 0;
        end else begin
            hold_cnt <= core_reset ? hold_cnt + 1 : 0;
        end
    end
    property p_init_vec;
        core_init == {5{core_reset}};
    endproperty
    a_init_vec: assert property (p_init_vec) else $error("init vector off");
    property p_wd_clear;
        watchdog_clear == core_reset;
    endproperty
    a_wd_clear: assert property (p_wd_clear) else $error("watchdog clear off");
    property p_run_excl;
        core_run |-> !core_reset && !watchdog_clear;
    endproperty
    a_run_excl: assert property (p_run_excl) else $error("run during reset");
    property p_startup;
        $fell(core_reset) |-> hold_cnt >= STARTUP_CYCLES;
    endproperty
    a_startup: assert property (p_startup) else $error("start-up delay short");
    property p_pin;
        !external_clear_pin_n [*4] |-> core_reset;
    endproperty
    a_pin: assert property (p_pin) else $error("pin reset missing");
    property p_wdt_run;
        core_run && !sleep_mode && watchdog_timeout |=> core_reset && watchdog_timeout_flag;
    endproperty
    a_wdt_run: assert property (p_wdt_run) else $error("run timeout wrong");
    property p_wdt_sleep;
        core_run && sleep_mode && watchdog_timeout |=>
            pc_sp_clear && !core_reset && watchdog_timeout_flag && power_down_flag;
    endproperty
    a_wdt_sleep: assert property (p_wdt_sleep) else $error("sleep timeout wrong");
    property p_pcsp_pulse;
        pc_sp_clear |=> !pc_sp_clear;
    endproperty
    a_pcsp_pulse: assert property (p_pcsp_pulse) else $error("clear pulse long");
    property p_wake;
        pc_sp_clear |-> !core_run [*2];
    endproperty
    a_wake: assert property (p_wake) else $error("wake too soon");
endmodule
`default_nettype wire
bind mrc_reset_ctrl mrc_reset_ctrl_checker #(.STARTUP_CYCLES(STARTUP_CYCLES)) chk_u (
    .clk(clk), .arst_n(arst_n), .external_clear_pin_n(external_clear_pin_n),
    .watchdog_timeout(watchdog_timeout), .sleep_mode(sleep_mode), .core_reset(core_reset),
    .core_run(core_run), .pc_sp_clear(pc_sp_clear), .core_init(core_init),
    .watchdog_clear(watchdog_clear), .watchdog_timeout_flag(watchdog_timeout_flag),
    .power_down_flag(power_down_flag));

// ### dv/mrc_reset_ctrl_tb_top.sv
// self-checking bench of the reset controller
`timescale 1ns/100ps
`default_nettype none
module mrc_reset_ctrl_tb_top;
    import mrc_pkg::*;
    localparam int SU = 20;
    localparam int BO = 4;
    logic clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] dati = 32'h0, dato, rd;
    logic ack, irq, low = 1'b0, wdt_to = 1'b0, sleep = 1'b0, clrw = 1'b0, halt = 1'b0;
    logic press = 1'b0, pin_n, core_reset, core_run, pcsp, wdclr, to_f, pd_f;
    logic [1:0] thr;
    logic [4:0] init;
    int error_cnt = 0, num_checks = 0, cycles = 0, n;
    logic [31:0] seed = 32'h2f5f;

    mrc_clear_switch sw_u (.clk(clk), .press(press), .pin_n(pin_n));
    mrc_reset_ctrl #(.STARTUP_CYCLES(SU), .BROWNOUT_CYCLES(BO)) dut_u (
        .clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dati), .wb_dat_o(dato), .wb_ack_o(ack),
        .irq_o(irq), .external_clear_pin_n(pin_n), .low_supply(low),
        .watchdog_timeout(wdt_to), .sleep_mode(sleep), .core_clr_wdt(clrw),
        .core_halt(halt), .brownout_threshold(thr), .core_reset(core_reset),
        .core_run(core_run), .pc_sp_clear(pcsp), .core_init(init), .watchdog_clear(wdclr),
        .watchdog_timeout_flag(to_f), .power_down_flag(pd_f));

    always #20 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // one classic cycle; ack and read data taken at the same edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dati <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rd = dato;
        cyc <= 1'b0;
        stb <= 1'b0;
        // a write lands at the ack edge; its effect shows one edge later
        repeat (2) @(posedge clk);
    endtask

    task automatic wait_run;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (core_run !== 1'b1);
    endtask

    task automatic dip(input int len, input logic exp);
        low <= 1'b1;
        repeat (len) @(posedge clk);
        low <= 1'b0;
        repeat (4) @(posedge clk);
        chk("lvr", {31'h0, exp}, {31'h0, core_reset});
        wait_run();
    endtask

    task automatic pulse_wdt;
        wdt_to <= 1'b1;
        @(posedge clk);
        wdt_to <= 1'b0;
        @(posedge clk);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        chk("init", 32'h1f, 32'(init));
        chk("flags", 32'h0, {30'h0, pd_f, to_f});
        arst_n <= 1'b1;
        wait_run();
        // run is seen one edge after the edge that launches it
        chk("startup", 32'h1, 32'(n == SU + 1));
        wb(1'b0, ADR_STATUS, 32'h0);
        chk("status", 32'h88, rd);
        wb(1'b0, 8'h14, 32'h0);
        chk("unmapped", 32'h0, rd);
        sel <= 4'he;
        wb(1'b1, ADR_CONFIG, 32'h0);
        sel <= 4'hf;
        wb(1'b0, ADR_CONFIG, 32'h0);
        chk("config", 32'(CFG_RESET), rd);
        seed = xs(seed);
        wb(1'b1, ADR_CONFIG, {29'h0, seed[1:0], 1'b1});
        chk("threshold", {30'h0, seed[1:0]}, {30'h0, thr});
        seed = xs(seed);
        dip(int'(seed % BO) + 1, 1'b0);
        dip(BO + 3, 1'b1);
        wb(1'b1, ADR_CONFIG, 32'h0);
        dip(BO + 3, 1'b0);
        // wake from sleep: crystal count, then short rc count
        for (int m = 0; m < 2; m++) begin
            wb(1'b1, ADR_CONFIG, m ? 32'h19 : 32'h01);
            sleep <= 1'b1;
            pulse_wdt();
            chk("sleep wdt", 32'hb, {28'h0, pcsp, core_reset, pd_f, to_f});
            sleep <= 1'b0;
            wait_run();
            chk("wake", 32'h1, 32'(n == (m ? WAKE_SHORT_CYC : WAKE_LONG_CYC)));
        end
        clrw <= 1'b1;
        @(posedge clk);
        clrw <= 1'b0;
        halt <= 1'b1;
        @(posedge clk);
        halt <= 1'b0;
        repeat (2) @(posedge clk);
        chk("halt", 32'h2, {30'h0, pd_f, to_f});
        wb(1'b1, ADR_IRQ_STATUS, 32'hf);
        press <= 1'b1;
        repeat (5) @(posedge clk);
        press <= 1'b0;
        chk("pin", 32'h6, {29'h0, core_reset, pd_f, to_f});
        wait_run();
        chk("irq masked", 32'h0, {31'h0, irq});
        wb(1'b1, ADR_IRQ_MASK, 32'h1);
        chk("irq", 32'h1, {31'h0, irq});
        wb(1'b1, ADR_IRQ_STATUS, 32'h1);
        chk("irq clear", 32'h0, {31'h0, irq});
        pulse_wdt();
        chk("wdt", 32'h7, {29'h0, core_reset, pd_f, to_f});
        wait_run();
        // power-on in mid-run must clear flags that are set now
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk("por init", 32'h1f, 32'(init));
        chk("por flags", 32'h0, {30'h0, pd_f, to_f});
        arst_n <= 1'b1;
        wait_run();
        chk("restart", 32'h1, 32'(n == SU + 1));
        test_done();
    end
endmodule
`default_nettype wire
